// ---- core/tsp_pkg.sv ----
// Constants for the single-pulse and capture timer
package tsp_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int CNT_W = 10;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int PIN_CNT = 2;
    localparam int PIN_CAPTURE = 0;
    localparam int PIN_EXTCLK = 1;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL0 = 4'h0;
    localparam logic [3:0] ADDR_CTRL1 = 4'h1;
    localparam logic [3:0] ADDR_CNT_LO = 4'h2;
    localparam logic [3:0] ADDR_CNT_HI = 4'h3;
    localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
    localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
    localparam logic [3:0] ADDR_CMPP_LO = 4'h6;
    localparam logic [3:0] ADDR_CMPP_HI = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int RUN_BIT = 3;
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int PINF_HI = 5;
    localparam int PINF_LO = 4;
    localparam int OC_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int DPX_BIT = 1;
    localparam int CCLR_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PULSE = 2'h2;
    localparam logic [1:0] PINF_RISE = 2'h0;
    localparam logic [1:0] PINF_FALL = 2'h1;
    localparam logic [1:0] PINF_BOTH = 2'h2;
    localparam logic [1:0] PINF_PULSE = 2'h3;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [9:0] CMP_RST = 10'h000;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;
    localparam logic [7:0] RD_ZERO = 8'h00;
    // Capture latch to flag, in timer clock cycles
    localparam int CAP_FLAG_DELAY = 1;
endpackage : tsp_pkg

// ---- core/tsp_timer.sv ----
// Single-pulse output and input-capture timer with register port
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns

// What this block does
// - Software raising the run bit triggers the pulse leading edge.
// - External clock pin rising edge sets the run bit in single-pulse mode.
// - Run rising gives the pulse leading edge at once; the counter zeroes one cycle later.
// - Run clear or compare-A match ends pulse; match also clears run.
// - Compare-A match in single-pulse mode sets the match-A flag.
// - Counter zeroes only when run rises in single-pulse mode.
// - Compare-P, clear source and duty swap ignored in single-pulse mode.
// - Pin function picks rising, falling or both; 11 captures nothing.
// - In capture mode the counter runs freely while run is high.
// - Active capture edge copies the counter into compare-A and flags.
// - Compare-P match clears the counter and flags; zero gives full range.
// - Capture mode drives no output and ignores output control bits.
// - Capture pulses under one timer clock may be missed.
// - Match-A flag rises one cycle after the capture latch.
// - Capture latch happens within one cycle of the detected edge.
// - Counter is ten bits and wraps after 3FF.
// - Run rising forces the output to its initial level.
// - Invert bit reverses the output pin polarity.
module tsp_timer
    import tsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic capture_input_pin,
    input wire logic ext_clock_pin,
    output logic timer_out,
    output logic timer_out_en_n,
    output logic match_a_flag,
    output logic match_p_flag
);

    // ************************************************************
    // State
    // ************************************************************
    logic counter_run_q, counter_run_d;
    logic run_prev_q;
    logic [1:0] timer_mode_q;
    logic [1:0] pin_function_q;
    logic output_initial_level_q;
    logic output_invert_q;
    logic duty_period_swap_q;
    logic clear_source_sel_q;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] cmp_a_q, cmp_a_d;
    logic [CNT_W-1:0] cmp_p_q, cmp_p_d;
    logic flag_a_q, flag_a_d;
    logic flag_p_q, flag_p_d;
    logic [CAP_FLAG_DELAY-1:0] cap_dly_q;
    logic out_q, out_d;
    logic out_en_n_q;
    logic [DATA_W-1:0] rd_data_q;
    logic [PIN_CNT-1:0] pin_raw;
    logic [PIN_CNT-1:0] pin_meta_q;
    logic [PIN_CNT-1:0] pin_sync_q;
    logic [PIN_CNT-1:0] pin_last_q;

    // ************************************************************
    // Decode
    // ************************************************************
    wire wr_ctrl0 = reg_wr && (reg_addr == ADDR_CTRL0);
    wire wr_ctrl1 = reg_wr && (reg_addr == ADDR_CTRL1);
    wire wr_a_lo = reg_wr && (reg_addr == ADDR_CMPA_LO);
    wire wr_a_hi = reg_wr && (reg_addr == ADDR_CMPA_HI);
    wire wr_p_lo = reg_wr && (reg_addr == ADDR_CMPP_LO);
    wire wr_p_hi = reg_wr && (reg_addr == ADDR_CMPP_HI);
    wire wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    // Mode 10 with pin function 11 is single pulse, mode 01 is capture; other codes idle here
    // Single-pulse decode
    wire pulse_mode = (timer_mode_q == MODE_PULSE) && (pin_function_q == PINF_PULSE);
    wire cap_mode = (timer_mode_q == MODE_CAPTURE);
    wire run_rise = counter_run_q && !run_prev_q;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    assign pin_raw[PIN_CAPTURE] = capture_input_pin;
    assign pin_raw[PIN_EXTCLK] = ext_clock_pin;
    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    pin_meta_q[gi] <= 1'b0;
                    pin_sync_q[gi] <= 1'b0;
                    pin_last_q[gi] <= 1'b0;
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                    pin_last_q[gi] <= pin_sync_q[gi];
                end
            end
        end
    endgenerate

    // Pulses under one cycle may slip past the sampler
    wire cap_rise = pin_sync_q[PIN_CAPTURE] && !pin_last_q[PIN_CAPTURE];
    wire cap_fall = !pin_sync_q[PIN_CAPTURE] && pin_last_q[PIN_CAPTURE];
    wire ext_edge = pin_sync_q[PIN_EXTCLK] && !pin_last_q[PIN_EXTCLK];

    // ************************************************************
    // Event decode
    // ************************************************************
    // Edge select, code 11 captures nothing
    wire cap_sel = (pin_function_q == PINF_RISE) ? cap_rise :
                   (pin_function_q == PINF_FALL) ? cap_fall :
                   (pin_function_q == PINF_BOTH) ? (cap_rise || cap_fall) : 1'b0;
    wire cap_fire = cap_mode && cap_sel;
    wire [CAP_FLAG_DELAY:0] cap_dly_next = {cap_dly_q, cap_fire};
    wire sp_match_a = pulse_mode && counter_run_q && !run_rise && (cnt_q == cmp_a_q);
    // Compare-P match, zero means wrap at full range
    wire p_hit = (cmp_p_q == CMP_RST) ? (cnt_q == {CNT_W{1'b1}}) : (cnt_q == cmp_p_q);
    wire cap_match_p = cap_mode && counter_run_q && !run_rise && p_hit;
    wire ext_set = pulse_mode && ext_edge;

    // ************************************************************
    // Run bit
    // ************************************************************
    // Hardware set wins over any clear in the same cycle
    always_comb begin
        counter_run_d = counter_run_q;
        if (wr_ctrl0) begin
            counter_run_d = reg_wdata[RUN_BIT];
        end
        if (sp_match_a) begin
            counter_run_d = 1'b0;
        end
        if (ext_set) begin
            counter_run_d = 1'b1;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    // Compare-P, clear source and swap bits never reach pulse mode
    // Pulse mode ignores compare-P
    always_comb begin
        cnt_d = cnt_q;
        if (run_rise) begin
            cnt_d = CNT_RST;
        end else if (cap_match_p && (cmp_p_q != CMP_RST)) begin
            cnt_d = CNT_RST;
        end else if (counter_run_q && (pulse_mode || cap_mode)) begin
            cnt_d = cnt_q + CNT_ONE;
        end
    end

    // ************************************************************
    // Compare registers
    // ************************************************************
    always_comb begin
        cmp_a_d = cmp_a_q;
        cmp_p_d = cmp_p_q;
        if (wr_a_lo) begin
            cmp_a_d[7:0] = reg_wdata;
        end
        if (wr_a_hi) begin
            cmp_a_d[CNT_W-1:8] = reg_wdata[CNT_W-9:0];
        end
        if (wr_p_lo) begin
            cmp_p_d[7:0] = reg_wdata;
        end
        if (wr_p_hi) begin
            cmp_p_d[CNT_W-1:8] = reg_wdata[CNT_W-9:0];
        end
        if (cap_fire) begin
            cmp_a_d = cnt_q;
        end
    end

    // ************************************************************
    // Flags
    // ************************************************************
    // Write one to clear; a set in the same cycle wins
    always_comb begin
        flag_a_d = flag_a_q;
        flag_p_d = flag_p_q;
        if (wr_status && reg_wdata[FLAG_A_BIT]) begin
            flag_a_d = 1'b0;
        end
        if (wr_status && reg_wdata[FLAG_P_BIT]) begin
            flag_p_d = 1'b0;
        end
        // Pulse match flag; delayed capture flag
        if (sp_match_a || cap_dly_q[CAP_FLAG_DELAY-1]) begin
            flag_a_d = 1'b1;
        end
        if (cap_match_p) begin
            flag_p_d = 1'b1;
        end
    end

    // ************************************************************
    // Output pin
    // ************************************************************
    // Pulse level follows run; initial level; invert
    always_comb begin
        out_d = output_initial_level_q ^ output_invert_q;
        if (!(pulse_mode && counter_run_d)) begin
            out_d = !output_initial_level_q ^ output_invert_q;
        end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            ADDR_CTRL0: rd_mux = {4'h0, counter_run_q, 3'h0};
            ADDR_CTRL1: rd_mux = {timer_mode_q, pin_function_q, output_initial_level_q,
                                  output_invert_q, duty_period_swap_q, clear_source_sel_q};
            ADDR_CNT_LO: rd_mux = cnt_q[7:0];
            ADDR_CNT_HI: rd_mux = {6'h00, cnt_q[CNT_W-1:8]};
            ADDR_CMPA_LO: rd_mux = cmp_a_q[7:0];
            ADDR_CMPA_HI: rd_mux = {6'h00, cmp_a_q[CNT_W-1:8]};
            ADDR_CMPP_LO: rd_mux = cmp_p_q[7:0];
            ADDR_CMPP_HI: rd_mux = {6'h00, cmp_p_q[CNT_W-1:8]};
            ADDR_STATUS: rd_mux = {6'h00, flag_p_q, flag_a_q};
            default: rd_mux = RD_ZERO;
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            counter_run_q <= 1'b0;
            run_prev_q <= 1'b0;
            cnt_q <= CNT_RST;
            cmp_a_q <= CMP_RST;
            cmp_p_q <= CMP_RST;
            flag_a_q <= 1'b0;
            flag_p_q <= 1'b0;
            cap_dly_q <= '0;
        end else begin
            counter_run_q <= counter_run_d;
            run_prev_q <= counter_run_q;
            cnt_q <= cnt_d;
            cmp_a_q <= cmp_a_d;
            cmp_p_q <= cmp_p_d;
            flag_a_q <= flag_a_d;
            flag_p_q <= flag_p_d;
            cap_dly_q <= cap_dly_next[CAP_FLAG_DELAY-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {timer_mode_q, pin_function_q, output_initial_level_q} <= CTRL1_RST[7:3];
            {output_invert_q, duty_period_swap_q, clear_source_sel_q} <= CTRL1_RST[2:0];
        end else if (wr_ctrl1) begin
            timer_mode_q <= reg_wdata[MODE_HI:MODE_LO];
            pin_function_q <= reg_wdata[PINF_HI:PINF_LO];
            output_initial_level_q <= reg_wdata[OC_BIT];
            output_invert_q <= reg_wdata[POL_BIT];
            duty_period_swap_q <= reg_wdata[DPX_BIT];
            clear_source_sel_q <= reg_wdata[CCLR_BIT];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b0;
            out_en_n_q <= 1'b1;
            rd_data_q <= RD_ZERO;
        end else begin
            out_q <= out_d;
            out_en_n_q <= !((timer_mode_q == MODE_PULSE) && (pin_function_q == PINF_PULSE));
            rd_data_q <= reg_rd ? rd_mux : RD_ZERO;
        end
    end

    assign reg_rdata = rd_data_q;
    assign timer_out = out_q;
    assign timer_out_en_n = out_en_n_q;
    assign match_a_flag = flag_a_q;
    assign match_p_flag = flag_p_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_sw_trigger: assert property (
        pulse_mode && wr_ctrl0 && reg_wdata[RUN_BIT] && !counter_run_q
        |=> counter_run_q ##1 (cnt_q == CNT_RST))
        else $error("software trigger did not start run");
    a_ext_trigger: assert property (
        ext_set && !counter_run_q |=> counter_run_q && run_rise)
        else $error("external edge did not set run");
    a_pulse_lead: assert property (
        pulse_mode && $rose(counter_run_q) && !$past(wr_ctrl1) |->
        (out_q == (output_initial_level_q ^ output_invert_q)) ##1 (cnt_q == CNT_RST))
        else $error("pulse leading edge missing");
    a_match_stop: assert property (
        sp_match_a && !ext_set && !wr_ctrl1 |=> !counter_run_q &&
        out_q == (!output_initial_level_q ^ output_invert_q))
        else $error("compare-A match did not end pulse");
    a_match_flag: assert property (
        sp_match_a |=> flag_a_q)
        else $error("compare-A match flag not set");
    a_restart_zero: assert property (
        run_rise |=> cnt_q == CNT_RST)
        else $error("counter not zeroed on run rise");
    a_pulse_hold: assert property (
        pulse_mode && !counter_run_q && !counter_run_d && !wr_ctrl1 |=> $stable(cnt_q))
        else $error("stopped counter changed");
    a_cap_none: assert property (
        cap_mode && pin_function_q == PINF_PULSE |-> !cap_fire)
        else $error("capture with edge select 11");
    a_cap_latch: assert property (
        cap_fire |=> cmp_a_q == $past(cnt_q))
        else $error("capture value wrong");
    a_cap_flag: assert property (
        cap_fire |=> ##1 flag_a_q)
        else $error("capture flag late");
    a_p_clear: assert property (
        cap_match_p |=> cnt_q == CNT_RST && flag_p_q)
        else $error("compare-P did not clear counter");
    a_cap_nodrive: assert property (
        cap_mode ##1 cap_mode |-> timer_out_en_n)
        else $error("output driven in capture mode");
endmodule : tsp_timer

// ---- sim/testbench.sv ----
// Self-checking bench for the single-pulse and capture timer
`timescale 1ns/1ns
module testbench;
    import tsp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic capture_input_pin, ext_clock_pin, timer_out, timer_out_en_n;
    logic match_a_flag, match_p_flag;
    logic cap_level = 1'b0;
    logic trig_level = 1'b0;
    logic [7:0] rv, rv2;
    logic seen;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int w;

    tsp_timer dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .capture_input_pin(capture_input_pin), .ext_clock_pin(ext_clock_pin),
        .timer_out(timer_out), .timer_out_en_n(timer_out_en_n),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
    tsp_pin_model pins (.ref_clk(ref_clk), .cap_level(cap_level), .trig_level(trig_level),
        .capture_input_pin(capture_input_pin), .ext_clock_pin(ext_clock_pin));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ************************************************************
    // Access and check tasks
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait on a flag: sel 0 watches A, 1 watches P
    task automatic wait_flag(input logic sel, input int lim);
        int i;
        i = 0;
        #1;
        while (i < lim && ((sel ? match_p_flag : match_a_flag) !== 1'b1)) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
    endtask : wait_flag

    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(ADDR_CTRL1, rv);
        chk(rv, CTRL1_RST);
        rd(4'h9, rv);
        chk(rv, RD_ZERO);
        wr(ADDR_CNT_LO, 8'h55);
        rd(ADDR_CNT_LO, rv);
        chk(rv, RD_ZERO);
        // Single pulse started by software, width from compare A
        wr(ADDR_CMPA_LO, 8'h05);
        wr(ADDR_CTRL1, 8'hB8);
        wr(ADDR_CTRL0, 8'h08);
        w = 0;
        repeat (30) begin
            #1;
            if (timer_out === 1'b1) w++;
            @(posedge ref_clk);
        end
        // Width is compare A plus two: the restart cycle and the match cycle
        chk(w[7:0], 8'h07);
        #1;
        chk({7'h00, match_a_flag}, 8'h01);
        chk({7'h00, timer_out_en_n}, 8'h00);
        rd(ADDR_CTRL0, rv);
        chk(rv, 8'h00);
        rd(ADDR_CNT_LO, rv);
        chk({7'h00, rv == 8'h00}, 8'h00);
        // Software stop before any match
        wr(ADDR_STATUS, 8'h03);
        wr(ADDR_CMPA_LO, 8'h80);
        wr(ADDR_CTRL0, 8'h08);
        wr(ADDR_CTRL0, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        chk({6'h00, timer_out, match_a_flag}, 8'h00);
        // Inverted pulse started from the trigger pin
        wr(ADDR_CMPA_LO, 8'h03);
        wr(ADDR_CTRL1, 8'hBC);
        @(posedge ref_clk) trig_level <= 1'b1;
        repeat (3) @(posedge ref_clk);
        trig_level <= 1'b0;
        seen = 1'b0;
        repeat (20) begin
            #1;
            if (timer_out === 1'b0) seen = 1'b1;
            @(posedge ref_clk);
        end
        #1;
        chk({6'h00, seen, timer_out}, 8'h03);
        chk({7'h00, match_a_flag}, 8'h01);
        // Capture on each pin-function code
        wr(ADDR_CMPP_LO, 8'h00);
        wr(ADDR_CTRL1, 8'h40);
        wr(ADDR_CTRL0, 8'h08);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CTRL1, {2'b01, 2'(k), 4'h0});
            wr(ADDR_STATUS, 8'h03);
            @(posedge ref_clk) cap_level <= ~cap_level;
            wait_flag(1'b0, 12);
            chk({7'h00, match_a_flag}, {7'h00, k != 3});
            chk({7'h00, timer_out_en_n}, 8'h01);
            if (k == 0) begin
                rd(ADDR_CMPA_LO, rv);
                rd(ADDR_CNT_LO, rv2);
                chk({7'h00, (rv2 != rv) && (rv2 - rv <= 8'd8)}, 8'h01);
            end
        end
        // Compare P clears the counter, zero gives full range
        wr(ADDR_CTRL0, 8'h00);
        wr(ADDR_CMPP_LO, 8'h14);
        wr(ADDR_STATUS, 8'h03);
        wr(ADDR_CTRL0, 8'h08);
        wait_flag(1'b1, 40);
        rd(ADDR_CNT_LO, rv);
        chk({7'h00, match_p_flag}, 8'h01);
        chk({7'h00, rv <= 8'h14}, 8'h01);
        wr(ADDR_CMPP_LO, 8'h00);
        wr(ADDR_STATUS, 8'h03);
        wait_flag(1'b1, 1100);
        rd(ADDR_CNT_LO, rv);
        chk({7'h00, match_p_flag}, 8'h01);
        chk({7'h00, rv < 8'h10}, 8'h01);
        report_and_stop();
    end
endmodule : testbench

// ---- sim/tsp_pin_model.sv ----
// Far-side model driving the capture input and external trigger pins
`timescale 1ns/1ns
module tsp_pin_model (
    input wire logic ref_clk,
    input wire logic cap_level,
    input wire logic trig_level,
    output logic capture_input_pin,
    output logic ext_clock_pin
);
    initial begin
        capture_input_pin = 1'b0;
        ext_clock_pin = 1'b0;
    end
    always @(posedge ref_clk) begin
        capture_input_pin <= cap_level;
        ext_clock_pin <= trig_level;
    end
endmodule : tsp_pin_model
